// ### rsf_pkg.sv
package rsf_pkg;
    // clock and link timing
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_BPS = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
    localparam int CHAR_BITS = 11;
    localparam int GAP_CHARS_X10 = 35;
    // frame geometry
    localparam int MAX_FRAME = 256;
    localparam int REG_COUNT_DEF = 17;
    localparam logic [8:0] MIN_FRAME = 9'h004;
    localparam logic [8:0] RD_LEN = 9'h008;
    localparam logic [8:0] WR_HDR = 9'h009;
    localparam logic [8:0] EXC_LEN = 9'h005;
    localparam logic [8:0] WR_REPLY = 9'h008;
    localparam logic [3:0] FRAME_BITS_LEFT = 4'ha;
    // addresses, function codes, error codes
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'hf7;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h10;
    localparam logic [7:0] FC_EXC_BIT = 8'h80;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_DATA = 8'h03;
    localparam logic [15:0] RD_MAX = 16'h007d;
    localparam logic [15:0] WR_MAX = 16'h007b;
    // check code
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    typedef enum logic [1:0] {MS_RECV = 2'b00, MS_CHECK = 2'b01, MS_WRITE = 2'b10, MS_SEND = 2'b11} rsf_ms_e;
    typedef enum logic [1:0] {RC_IDLE = 2'b00, RC_START = 2'b01, RC_DATA = 2'b10} rsf_rc_e;
    typedef enum logic {TS_LOAD = 1'b0, TS_SHIFT = 1'b1} rsf_ts_e;
endpackage

// ### rsf_crc_if.sv
`timescale 1ns/100ps
interface rsf_crc_if;
    logic init;
    logic en;
    logic [7:0] data;
    logic [15:0] crc;
    modport eng (input init, input en, input data, output crc);
    modport user (output init, output en, output data, input crc);
endinterface

// ### rsf_crc16.sv
`timescale 1ns/100ps
module rsf_crc16 (
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i,     // sync reset, high
    input wire logic ce_i,      // clock enable
    rsf_crc_if.eng c            // byte feed and result
);
    import rsf_pkg::*;

    // one byte per cycle, all eight shifts unrolled by the loop
    function automatic logic [15:0] crc_step(input logic [15:0] cin, input logic [7:0] d);
        logic [15:0] v;
        v = cin ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
        end
        return v;
    endfunction

    // running check register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            c.crc <= CRC_INIT;
        end else if (ce_i) begin
            if (c.init) begin
                c.crc <= CRC_INIT;
            end else if (c.en) begin
                c.crc <= crc_step(c.crc, c.data);
            end
        end
    end

    crc_init_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i) c.init |=> c.crc == CRC_INIT)
        else $error("check register not preset after init");
endmodule

// ### rsf_frame_handler.sv
// Function
// - characters are start 0, eight data bits lsb first, two stop 1s
// - first byte is the slave address, valid from 1 to 247
// - second byte is the function code selecting the operation
// - reply only when address byte equals own address, else stay silent
// - good addressed frame is executed and answered with its result
// - check code mismatch: discard, execute nothing, send nothing
// - every reply starts with the own address byte
// - normal reply echoes the received function code
// - code 03h reads consecutive 16-bit registers back to host
// - code 10h writes n 16-bit values into consecutive registers
// - check code: preset ffff, xor byte low, eight shifts with a001
// - other errors answered with function code plus 128 and error code
// - error 01h bad function, 02h bad address, 03h bad data value
// - check code sent last, low byte first
`timescale 1ns/100ps
module rsf_frame_handler #(
    parameter int BIT_CYC = rsf_pkg::BIT_CYCLES,   // clocks per bit
    parameter int REG_COUNT = rsf_pkg::REG_COUNT_DEF // implemented registers
) (
    input wire logic sys_clk_i,         // 100 MHz clock
    input wire logic rst_i,             // sync reset, high
    input wire logic ce_i,              // clock enable, freezes all
    input wire logic rx_i,              // serial line in
    input wire logic [7:0] own_addr_i,  // configured slave address
    input wire logic [15:0] rd_data_i,  // register store read data
    output logic tx_o,                  // serial line out
    output logic tx_oe_o,               // line driver enable, high drives
    output logic [15:0] rd_addr_o,      // register store read address
    output logic wr_en_o,               // register write strobe
    output logic [15:0] wr_addr_o,      // register write address
    output logic [15:0] wr_data_o       // register write data
);
    import rsf_pkg::*;

    localparam logic [23:0] BIT_C = 24'(BIT_CYC - 1);
    localparam logic [23:0] HALF_C = 24'(BIT_CYC / 2);
    localparam logic [23:0] GAP_C = 24'((BIT_CYC * CHAR_BITS * GAP_CHARS_X10) / 10 + 1);

    logic [7:0] frame_mem [MAX_FRAME];
    rsf_rc_e rc;
    logic [23:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rshift;
    logic rx_stb, rx_ferr;
    logic [23:0] idle_cnt;
    logic gap_stb;
    rsf_ms_e ms;
    rsf_ts_e ts;
    logic synced, bad;
    logic [8:0] len, tx_len, tidx;
    logic [7:0] fc, exc;
    logic [15:0] sa, cnt, widx, word;
    logic [23:0] tcnt;
    logic [3:0] tbits;
    logic [9:0] tshift;
    logic [7:0] fc_w, next_exc, next_byte;
    logic [15:0] sa_w, n_w;
    logic [16:0] end_w;
    logic [8:0] wr_ix;
    logic accept;

    rsf_crc_if rcrc();
    rsf_crc_if tcrc();

    rsf_crc16 u_rx_crc (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .c(rcrc));
    rsf_crc16 u_tx_crc (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .c(tcrc));

    // character receiver, samples mid-bit; second stop bit not checked
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rc <= RC_IDLE;
            rcnt <= 24'h000000;
            rbit <= 4'h0;
            rshift <= 8'h00;
            rx_stb <= 1'b0;
            rx_ferr <= 1'b0;
        end else if (ce_i) begin
            rx_stb <= 1'b0;
            case (rc)
                RC_IDLE: begin
                    if (!rx_i) begin
                        rc <= RC_START;
                        rcnt <= HALF_C;
                    end
                end
                RC_START: begin
                    if (rcnt != 24'h000000) begin
                        rcnt <= rcnt - 24'h000001;
                    end else begin
                        rc <= rx_i ? RC_IDLE : RC_DATA;
                        rcnt <= BIT_C;
                        rbit <= 4'h0;
                    end
                end
                RC_DATA: begin
                    if (rcnt != 24'h000000) begin
                        rcnt <= rcnt - 24'h000001;
                    end else if (rbit == 4'h8) begin
                        rx_stb <= 1'b1;
                        rx_ferr <= !rx_i;
                        rc <= RC_IDLE;
                    end else begin
                        rshift <= {rx_i, rshift[7:1]};
                        rbit <= rbit + 4'h1;
                        rcnt <= BIT_C;
                    end
                end
                default: rc <= RC_IDLE;
            endcase
        end
    end

    // idle gap timer, measured from the middle of the first stop bit of the last character
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            idle_cnt <= 24'h000000;
            gap_stb <= 1'b0;
        end else if (ce_i) begin
            gap_stb <= 1'b0;
            if (rc != RC_IDLE || !rx_i) begin
                idle_cnt <= 24'h000000;
            end else if (idle_cnt != GAP_C) begin
                idle_cnt <= idle_cnt + 24'h000001;
                gap_stb <= (idle_cnt == GAP_C - 24'h000001);
            end
        end
    end

    // frame store; bytes past the end are dropped and mark the frame bad
    always_ff @(posedge sys_clk_i) begin
        if (ce_i && ms == MS_RECV && rx_stb && len != 9'(MAX_FRAME)) begin
            frame_mem[len[7:0]] <= rshift;
        end
    end

    // frame decode; stale bytes beyond len are masked by the length tests
    always_comb begin
        fc_w = frame_mem[1];
        sa_w = {frame_mem[2], frame_mem[3]};
        n_w = {frame_mem[4], frame_mem[5]};
        end_w = {1'b0, sa_w} + {1'b0, n_w};
        wr_ix = 9'h007 + {widx[7:0], 1'b0};
        accept = !bad && len >= MIN_FRAME && rcrc.crc == CRC_GOOD && frame_mem[0] == own_addr_i
            && own_addr_i >= ADDR_MIN && own_addr_i <= ADDR_MAX;
        next_exc = EXC_NONE;
        if (fc_w == FC_READ) begin
            if (len != RD_LEN || n_w == 16'h0000 || n_w > RD_MAX) begin
                next_exc = EXC_DATA;
            end else if (end_w > 17'(REG_COUNT)) begin
                next_exc = EXC_ADDR;
            end
        end else if (fc_w == FC_WRITE) begin
            if (len < WR_HDR || n_w == 16'h0000 || n_w > WR_MAX || frame_mem[6] != {n_w[6:0], 1'b0}
                || len != WR_HDR + {n_w[7:0], 1'b0}) begin
                next_exc = EXC_DATA;
            end else if (end_w > 17'(REG_COUNT)) begin
                next_exc = EXC_ADDR;
            end
        end else begin
            next_exc = EXC_FUNC;
        end
    end

    // reply byte for the current position
    always_comb begin
        if (tidx == 9'h000) begin
            next_byte = own_addr_i;
        end else if (tidx == 9'h001) begin
            next_byte = (exc != EXC_NONE) ? (fc | FC_EXC_BIT) : fc;
        end else if (tidx == tx_len - 9'h002) begin
            next_byte = tcrc.crc[7:0];
        end else if (tidx == tx_len - 9'h001) begin
            next_byte = tcrc.crc[15:8];
        end else if (exc != EXC_NONE) begin
            next_byte = exc;
        end else if (fc == FC_WRITE) begin
            next_byte = frame_mem[tidx[7:0]];
        end else if (tidx == 9'h002) begin
            next_byte = {cnt[6:0], 1'b0};
        end else if (tidx[0]) begin
            next_byte = rd_data_i[15:8];
        end else begin
            next_byte = word[7:0];
        end
    end

    // frame sequencer: collect, check, write, send
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ms <= MS_RECV;
            ts <= TS_LOAD;
            synced <= 1'b0;
            bad <= 1'b0;
            len <= 9'h000;
            fc <= 8'h00;
            exc <= 8'h00;
            sa <= 16'h0000;
            cnt <= 16'h0000;
            widx <= 16'h0000;
            word <= 16'h0000;
            tx_len <= 9'h000;
            tidx <= 9'h000;
            tcnt <= 24'h000000;
            tbits <= 4'h0;
            tshift <= 10'h3ff;
            tx_o <= 1'b1;
            tx_oe_o <= 1'b0;
            rd_addr_o <= 16'h0000;
            wr_en_o <= 1'b0;
            wr_addr_o <= 16'h0000;
            wr_data_o <= 16'h0000;
            rcrc.init <= 1'b0;
            rcrc.en <= 1'b0;
            rcrc.data <= 8'h00;
            tcrc.init <= 1'b0;
            tcrc.en <= 1'b0;
            tcrc.data <= 8'h00;
        end else if (ce_i) begin
            rcrc.init <= 1'b0;
            rcrc.en <= 1'b0;
            tcrc.init <= 1'b0;
            tcrc.en <= 1'b0;
            wr_en_o <= 1'b0;
            // bytes heard while busy mean we lost the frame start
            if (gap_stb) begin
                synced <= 1'b1;
            end else if (rx_stb && ms != MS_RECV) begin
                synced <= 1'b0;
            end
            case (ms)
                MS_RECV: begin
                    if (rx_stb) begin
                        rcrc.en <= 1'b1;
                        rcrc.data <= rshift;
                        if (len == 9'(MAX_FRAME)) begin
                            bad <= 1'b1;
                        end else begin
                            len <= len + 9'h001;
                        end
                        if (rx_ferr || !synced) begin
                            bad <= 1'b1;
                        end
                    end
                    if (gap_stb && len != 9'h000) begin
                        ms <= MS_CHECK;
                    end
                end
                MS_CHECK: begin
                    fc <= fc_w;
                    sa <= sa_w;
                    cnt <= n_w;
                    exc <= next_exc;
                    rd_addr_o <= sa_w;
                    widx <= 16'h0000;
                    tidx <= 9'h000;
                    ts <= TS_LOAD;
                    len <= 9'h000;
                    bad <= 1'b0;
                    rcrc.init <= 1'b1;
                    if (next_exc != EXC_NONE) begin
                        tx_len <= EXC_LEN;
                    end else if (fc_w == FC_WRITE) begin
                        tx_len <= WR_REPLY;
                    end else begin
                        tx_len <= EXC_LEN + {n_w[7:0], 1'b0};
                    end
                    if (!accept) begin
                        ms <= MS_RECV;
                    end else if (next_exc == EXC_NONE && fc_w == FC_WRITE) begin
                        ms <= MS_WRITE;
                    end else begin
                        ms <= MS_SEND;
                    end
                end
                MS_WRITE: begin
                    wr_en_o <= 1'b1;
                    wr_addr_o <= sa + widx;
                    wr_data_o <= {frame_mem[wr_ix[7:0]], frame_mem[wr_ix[7:0] + 8'h01]};
                    widx <= widx + 16'h0001;
                    if (widx == cnt - 16'h0001) begin
                        ms <= MS_SEND;
                    end
                end
                MS_SEND: begin
                    case (ts)
                        TS_LOAD: begin
                            if (tidx == tx_len) begin
                                tx_oe_o <= 1'b0;
                                tcrc.init <= 1'b1;
                                ms <= MS_RECV;
                            end else begin
                                tx_oe_o <= 1'b1;
                                tx_o <= 1'b0;
                                tshift <= {2'b11, next_byte};
                                tbits <= FRAME_BITS_LEFT;
                                tcnt <= BIT_C;
                                ts <= TS_SHIFT;
                                tidx <= tidx + 9'h001;
                                if (tidx < tx_len - 9'h002) begin
                                    tcrc.en <= 1'b1;
                                    tcrc.data <= next_byte;
                                end
                                // latch the word at its high byte, then fetch the next one
                                if (exc == EXC_NONE && fc == FC_READ && tidx >= 9'h003 && tidx[0]) begin
                                    word <= rd_data_i;
                                    rd_addr_o <= rd_addr_o + 16'h0001;
                                end
                            end
                        end
                        TS_SHIFT: begin
                            if (tcnt != 24'h000000) begin
                                tcnt <= tcnt - 24'h000001;
                            end else if (tbits == 4'h0) begin
                                ts <= TS_LOAD;
                            end else begin
                                tx_o <= tshift[0];
                                tshift <= {1'b1, tshift[9:1]};
                                tbits <= tbits - 4'h1;
                                tcnt <= BIT_C;
                            end
                        end
                        default: ts <= TS_LOAD;
                    endcase
                end
                default: ms <= MS_RECV;
            endcase
        end
    end

    // checks on the transmitter, the drop decisions and the write strobe
    line_idle_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) !tx_oe_o |-> tx_o)
        else $error("line not released high");
    start_bit_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) $rose(tx_oe_o) |-> !tx_o)
        else $error("reply did not open with a start bit");
    stop_bits_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (ms == MS_SEND && ts == TS_SHIFT && tbits < 4'h2) |-> tx_o)
        else $error("stop bit not high");
    crc_drop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (ms == MS_CHECK && rcrc.crc != CRC_GOOD) |=> (ms == MS_RECV && !tx_oe_o))
        else $error("frame with bad check code not dropped");
    addr_drop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (ms == MS_CHECK && frame_mem[0] != own_addr_i) |=> ms == MS_RECV)
        else $error("foreign frame not ignored");
    short_drop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (ms == MS_CHECK && len < MIN_FRAME) |=> ms == MS_RECV)
        else $error("short frame not dropped");
    first_addr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (ms == MS_SEND && ts == TS_LOAD && tidx == 9'h000 && tx_len != 9'h000) |=> tshift[7:0] == own_addr_i)
        else $error("reply does not start with own address");
    exc_func_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (ms == MS_SEND && ts == TS_LOAD && tidx == 9'h001 && exc != EXC_NONE) |=> tshift[7])
        else $error("error reply lacks the top function bit");
    write_win_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_en_o |-> (ms == MS_WRITE || ms == MS_SEND))
        else $error("register write outside a write command");

    reply_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(tx_oe_o));
    write_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(wr_en_o));
    exc_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) ms == MS_SEND && exc != EXC_NONE);
endmodule

// ### rsf_host_model.sv
`timescale 1ns/100ps
module rsf_host_model #(
    parameter int BIT_CYC = 16 // clocks per bit
) (
    input wire logic sys_clk_i, // system clock
    input wire logic tx_i,      // device serial out
    input wire logic tx_oe_i,   // device driver enable
    output logic line_o         // host serial out
);
    logic [7:0] rx_q[$];
    logic char_ok;

    // bus is biased high, so a quiet host reads as idle
    initial line_o = 1'b1;

    // check code as the host forms it
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction

    // one bit time, changed just after an edge
    task automatic put(input logic v);
        #1 line_o = v;
        repeat (BIT_CYC) @(posedge sys_clk_i);
    endtask

    // whole frame; may spoil the check code or one first stop bit
    task automatic send_frame(input logic [7:0] q[$], input bit bad_crc, input int bad_stop);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0, bad_crc};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        @(posedge sys_clk_i);
        foreach (q[i]) begin
            put(1'b0);
            for (int k = 0; k < 8; k++) put(q[i][k]);
            put(i != bad_stop);
            put(1'b1);
        end
    endtask

    // collects reply characters until the line stays quiet
    task automatic recv_frame(input int wait_cyc);
        int t;
        logic [7:0] b;
        rx_q = {};
        char_ok = 1'b1;
        forever begin
            t = 0;
            while (!(tx_oe_i === 1'b1 && tx_i === 1'b0) && t < wait_cyc) begin
                @(posedge sys_clk_i);
                t++;
            end
            if (t >= wait_cyc) return;
            repeat (BIT_CYC / 2) @(posedge sys_clk_i);
            for (int k = 0; k < 10; k++) begin
                repeat (BIT_CYC) @(posedge sys_clk_i);
                if (k < 8) b[k] = tx_i;
                else char_ok &= (tx_i === 1'b1) && (tx_oe_i === 1'b1);
            end
            rx_q.push_back(b);
            wait_cyc = 3 * BIT_CYC;
        end
    endtask
endmodule

// ### rsf_frame_handler_bench.sv
`timescale 1ns/100ps
module rsf_frame_handler_bench;
    // short bit time keeps the run small
    localparam int BC = 8;
    localparam int GAP = BC * 11 * 35 / 10 + 1;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] own_addr = 8'h01;
    logic line_rx, tx, tx_oe, wr_en;
    logic [15:0] rd_addr, wr_addr, wr_data, rd_data;
    logic [15:0] regs [0:16];
    int failures = 0;
    int checks_done = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    rsf_frame_handler #(.BIT_CYC(BC), .REG_COUNT(17)) rsf_frame_handler_i (
        .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .rx_i(line_rx), .own_addr_i(own_addr),
        .rd_data_i(rd_data), .tx_o(tx), .tx_oe_o(tx_oe), .rd_addr_o(rd_addr), .wr_en_o(wr_en),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    rsf_host_model #(.BIT_CYC(BC)) rsf_host_model_i (
        .sys_clk_i(sys_clk), .tx_i(tx), .tx_oe_i(tx_oe), .line_o(line_rx));

    // store model: reads settle at once, out of range reads look like junk
    assign rd_data = (rd_addr < 16'h0011) ? regs[rd_addr[4:0]] : 16'hdead;
    initial begin
        for (int i = 0; i < 17; i++) regs[i] = 16'h1000 + 16'(i);
        regs[12] = 16'h0000;
        regs[13] = 16'h1388;
    end
    always @(posedge sys_clk) if (wr_en === 1'b1 && wr_addr < 16'h0011) regs[wr_addr[4:0]] <= wr_data;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one request and its expected reply; no reply bytes means silence
    task automatic xact(input string what, input int rn, input logic [103:0] rq, input int en,
                        input logic [103:0] ex, input bit bad_crc = 1'b0, input int bad_stop = -1,
                        input int hold = 0);
        logic [7:0] req[$];
        logic [7:0] exp[$];
        logic [15:0] c;
        for (int i = rn - 1; i >= 0; i--) req.push_back(rq[8 * i +: 8]);
        for (int i = en - 1; i >= 0; i--) exp.push_back(ex[8 * i +: 8]);
        c = rsf_host_model_i.crc16(exp);
        if (en > 0) exp = {exp, c[7:0], c[15:8]};
        rsf_host_model_i.send_frame(req, bad_crc, bad_stop);
        // enable held low past the gap: a frozen timer must not let the reply start
        if (hold > 0) begin
            #1 ce = 1'b0;
            repeat (hold) @(posedge sys_clk);
            check({what, " frozen"}, {15'h0, tx_oe}, 16'h0000);
            #1 ce = 1'b1;
        end
        rsf_host_model_i.recv_frame(GAP + 12 * BC);
        check({what, " count"}, 16'(rsf_host_model_i.rx_q.size()), 16'(exp.size()));
        foreach (exp[i]) check({what, " byte"}, {8'h00, rsf_host_model_i.rx_q[i]}, {8'h00, exp[i]});
        check({what, " format"}, {15'h0, rsf_host_model_i.char_ok}, 16'h0001);
        check({what, " release"}, {15'h0, tx_oe}, 16'h0000);
        repeat (GAP + 4) @(posedge sys_clk);
    endtask

    task automatic t_read();
        check("crc", rsf_host_model_i.crc16({8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h13, 8'h88}), 16'h65f7);
        xact("read", 6, 104'h0103000c0002, 7, 104'h01030400001388);
        xact("frozen", 6, 104'h0103000c0002, 7, 104'h01030400001388, 1'b0, -1, 400);
        xact("top", 6, 104'h0103000f0002, 7, 104'h010304100f1010);
    endtask

    task automatic t_write();
        xact("write", 13, 104'h0110000000030600021388000a, 6, 104'h011000000003);
        xact("readback", 6, 104'h010300000003, 9, 104'h01030600021388000a);
    endtask

    // spoiled check code must leave the register untouched
    task automatic t_bad_crc();
        xact("bad crc", 9, 104'h011000050001021234, 0, 104'h0, 1'b1);
        xact("kept", 6, 104'h010300050001, 5, 104'h0103021005);
    endtask

    task automatic t_not_mine();
        xact("other", 6, 104'h020300000001, 0, 104'h0);
        xact("broadcast", 6, 104'h000300000001, 0, 104'h0);
    endtask

    task automatic t_errors();
        xact("bad fc", 6, 104'h010400000001, 3, 104'h018401);
        xact("range", 6, 104'h010300100002, 3, 104'h018302);
        xact("zero n", 6, 104'h010300000000, 3, 104'h018303);
        xact("bytes", 9, 104'h011000000001040001, 3, 104'h019003);
    endtask

    task automatic t_drop();
        xact("short", 1, 104'h01, 0, 104'h0);
        xact("framing", 6, 104'h010300000001, 0, 104'h0, 1'b0, 2);
    endtask

    // main sequence: reset, then each scenario with a gap between
    initial begin
        repeat (11) @(posedge sys_clk);
        check("reset tx", {15'h0, tx}, 16'h0001);
        check("reset oe", {15'h0, tx_oe}, 16'h0000);
        check("reset wr", {15'h0, wr_en}, 16'h0000);
        @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (GAP + 4) @(posedge sys_clk);
        t_read();
        t_write();
        t_bad_crc();
        t_not_mine();
        t_errors();
        t_drop();
        print_verdict();
    end

    // hang guard, well above the expected run of some thirty thousand cycles
    initial begin
        repeat (100000) @(posedge sys_clk);
        failures++;
        print_verdict();
    end
endmodule
